// ==== bench/poc_command_words_bench.sv ====
`timescale 1ns/1ps
module poc_command_words_bench;
	import poc_pkg::*;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0] d;
		logic [7:0] in_service_register;
	} poc_row_t;
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	logic io_wr, io_rd, int_ack, rvalid, intr, avalid, ok;
	logic [15:0] addr;
	logic [15:0] irq = 16'h0000;
	logic [15:0] chan_mask = 16'h0000;
	logic [1:0] auto_eoi = 2'h0;
	logic [1:0] init_done = 2'h0;
	logic [7:0] wdata, rdata, q;
	logic [3:0] alevel;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	poc_row_t rows [11] = '{
		'{16'h0020, 8'h40, 8'hFB},
		'{16'h0030, 8'h20, 8'hFB},
		'{16'h0020, 8'h30, 8'hFB},
		'{16'h0020, 8'h20, 8'hFA},
		'{16'h0020, 8'h67, 8'h7A},
		'{16'h0020, 8'hC3, 8'h7A},
		'{16'h0020, 8'h20, 8'h6A},
		'{16'h0020, 8'hA0, 8'h4A},
		'{16'h0020, 8'h20, 8'h0A},
		'{16'h0020, 8'hE1, 8'h08},
		'{16'h0020, 8'h20, 8'h00}};
	always #4 i_clk_sys = ~i_clk_sys;
	poc_command_words poc_command_words_i (.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b), .i_io_wr(io_wr), .i_io_rd(io_rd),
		.i_io_addr(addr), .i_io_wdata(wdata), .o_io_rdata(rdata),
		.o_io_rdata_valid(rvalid), .i_int_ack(int_ack), .o_intr(intr),
		.o_ack_level(alevel), .o_ack_valid(avalid), .i_irq(irq),
		.i_chan_mask(chan_mask), .i_auto_eoi(auto_eoi),
		.i_init_done(init_done));
	poc_host_model poc_host_model_i (.i_clk_sys(i_clk_sys),
		.o_io_wr(io_wr), .o_io_rd(io_rd), .o_io_addr(addr),
		.o_io_wdata(wdata), .o_int_ack(int_ack), .i_io_rdata(rdata),
		.i_io_rdata_valid(rvalid), .i_ack_level(alevel),
		.i_ack_valid(avalid));
	// ====================================================
	// Checking and host helpers
	task automatic check_val(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		poc_host_model_i.cyc(2'h0, a, d, ok, q);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		poc_host_model_i.cyc(2'h1, a, 8'h00, ok, q);
		check_val("read valid", 8'h01, {7'h00, ok});
		check_val("read data", e, q);
	endtask
	// A refused acknowledge is expected as FF.
	task automatic ack(input logic [7:0] e);
		poc_host_model_i.cyc(2'h2, 16'h0000, 8'h00, ok, q);
		check_val("ack level", e, ok ? q : 8'hFF);
	endtask
	task automatic intr_is(input logic e);
		@(negedge i_clk_sys);
		check_val("intr", {7'h00, e}, {7'h00, intr});
	endtask
	task automatic wait_pins();
		repeat (6) @(posedge i_clk_sys);
	endtask
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// The run needs well under a thousand cycles.
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			end_of_test();
		end
	end
	// ====================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		irq <= 16'h00FB;
		wait_pins();
		rd(16'h0020, 8'hFB);
		wr(16'h0020, 8'h09);
		rd(16'h0020, 8'hFB);
		ack(8'h00);
		intr_is(1'b0);
		wr(16'h0020, 8'h48);
		intr_is(1'b0);
		wr(16'h0020, 8'h68);
		intr_is(1'b1);
		for (int l = 1; l < 8; l++) begin
			if (l != 2) begin
				ack(8'(l));
			end
		end
		intr_is(1'b0);
		$display("test special mask done");
		wr(16'h0020, 8'h28);
		irq <= 16'h0000;
		wr(16'h00A0, 8'h0B);
		rd(16'h00A0, 8'h00);
		wr(16'h0020, 8'h0B);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(16'h0020, rows[i].in_service_register);
		end
		$display("test commands done");
		irq <= 16'h00A0;
		wait_pins();
		wr(16'h0020, 8'h0C);
		rd(16'h0020, 8'h85);
		rd(16'h0020, 8'h20);
		$display("test poll done");
		init_done <= 2'h1;
		@(posedge i_clk_sys);
		init_done <= 2'h0;
		rd(16'h0020, 8'hA0);
		ack(8'h05);
		wr(16'h0020, 8'h65);
		$display("test init done");
		auto_eoi <= 2'h1;
		wr(16'h0020, 8'h80);
		ack(8'h05);
		ack(8'h07);
		wr(16'h0020, 8'h00);
		ack(8'h05);
		ack(8'h05);
		auto_eoi <= 2'h0;
		$display("test auto end done");
		irq <= 16'h0200;
		chan_mask <= 16'h0004;
		wait_pins();
		intr_is(1'b0);
		ack(8'hFF);
		chan_mask <= 16'h0000;
		repeat (2) @(posedge i_clk_sys);
		intr_is(1'b1);
		ack(8'h09);
		$display("test cascade done");
		i_rst_b <= 1'b0;
		repeat (5) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		wait_pins();
		rd(16'h00A0, 8'h02);
		wr(16'h0020, 8'h0B);
		rd(16'h0020, 8'h00);
		$display("test reset done");
		end_of_test();
	end
endmodule

// ==== bench/poc_host_model.sv ====
`timescale 1ns/1ps
module poc_host_model (
	// Clock
	input wire logic i_clk_sys,
	// I/O and acknowledge cycles
	output logic o_io_wr,
	output logic o_io_rd,
	output logic [15:0] o_io_addr,
	output logic [7:0] o_io_wdata,
	output logic o_int_ack,
	// Answers from the controller
	input wire logic [7:0] i_io_rdata,
	input wire logic i_io_rdata_valid,
	input wire logic [3:0] i_ack_level,
	input wire logic i_ack_valid
);
	initial begin
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_int_ack = 1'b0;
		o_io_addr = 16'h0000;
		o_io_wdata = 8'h00;
	end
	// ====================================================
	// One cycle: kind 0 write, 1 read, 2 acknowledge.
	// Idle buses carry the inverse so stale values never look valid.
	task automatic cyc(input logic [1:0] k, input logic [15:0] a,
		input logic [7:0] d, output logic ok, output logic [7:0] q);
		@(posedge i_clk_sys);
		o_io_wr <= k == 2'h0;
		o_io_rd <= k == 2'h1;
		o_int_ack <= k == 2'h2;
		o_io_addr <= a;
		o_io_wdata <= d[4:3] == 2'h1 ? {1'b0, d[6:0]} : d;
		@(posedge i_clk_sys);
		o_io_wr <= 1'b0;
		o_io_rd <= 1'b0;
		o_int_ack <= 1'b0;
		o_io_addr <= ~a;
		o_io_wdata <= ~d;
		@(posedge i_clk_sys);
		ok = k == 2'h0 ||
			(k == 2'h1 ? i_io_rdata_valid : i_ack_valid) === 1'b1;
		q = k == 2'h1 ? i_io_rdata : {4'h0, i_ack_level};
	endtask
endmodule

// ==== hw/poc_command_words.sv ====
`timescale 1ns/1ps
// Function
// - After reset or init: fully nested, non-rotating non-specific EOI default.
// - Both command words at base port; bits 4:3 pick which word.
// - Code 001 clears highest in-service bit; code 010 does nothing.
// - Code 011 clears in-service bit of the selected level, no rotation.
// - Code 100 enables rotation in auto end of service; 000 disables.
// - Code 101 clears highest in-service bit and makes it lowest.
// - Code 110 sets priority order from selected level, no clearing.
// - Code 111 clears selected level's in-service bit, makes it lowest.
// - Bits 2:0 give binary level 0-7 (master) or 8-15 (slave).
// - Command field of second word resets to non-specific EOI.
// - Third word resets with special mask off, read request register.
// - Special mask mode changes only when the enable bit is set.
// - In special mask mode unmasked levels not in service interrupt regardless of priority.
// - Poll bit makes next read an acknowledge returning encoded level.
// - Bits 1:0 pick read source: 10 request, 11 in-service.
// - After initialization a base port read returns the request register.
// - Read selection persists across reads until rewritten.
// - Fourth init word bit 1 selects automatic end of service mode.
// - Masking master input 2 blocks all slave requests.
module poc_command_words
	import poc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Host I/O cycles
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [15:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	output logic [7:0] o_io_rdata,
	output logic o_io_rdata_valid,
	// Interrupt acknowledge from the processor
	input wire logic i_int_ack,
	output logic o_intr,
	output logic [3:0] o_ack_level,
	output logic o_ack_valid,
	// Request pins and settings from the init and mask logic
	input wire logic [15:0] i_irq,
	input wire logic [15:0] i_chan_mask,
	input wire logic [1:0] i_auto_eoi,
	input wire logic [1:0] i_init_done
);

	poc_state_t q;
	poc_state_t next_q;
	logic [1:0][7:0] req;
	logic [1:0][3:0] win;
	logic [1:0][3:0] top;

	// ============================================================
	// Priority resolution
	// Returns {found, level}; scans from lowest down to lowest+1 so the last
	// hit, the first in rotated order, wins.
	function automatic logic [3:0] first_hit(input logic [7:0] v,
		input logic [2:0] lowest);
		logic [3:0] r;
		logic [2:0] l;
		r = 4'h0;
		for (int i = 8; i >= 1; i--) begin
			l = 3'(lowest + 3'(i));
			if (v[l]) begin
				r = {1'b1, l};
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] rank(input logic [2:0] l,
		input logic [2:0] lowest);
		return 3'(l - lowest - 3'h1);
	endfunction

	always_comb begin
		logic [3:0] cand;
		cand = 4'h0;
		req = '0;
		win = '0;
		top = '0;
		for (int c = 1; c >= 0; c--) begin
			req[c] = q.irq_stable[8*c +: 8] & ~i_chan_mask[8*c +: 8];
			if (c == 0) begin
				req[0][CASCADE_LEVEL] = win[1][3] & ~i_chan_mask[CASCADE_LEVEL];
			end
			top[c] = first_hit(q.in_service_register[c], q.lowest[c]);
			cand = first_hit(req[c] & ~q.in_service_register[c], q.lowest[c]);
			if (q.special_mask[c]) begin
				win[c] = cand;
			end else if (cand[3] && (!top[c][3] ||
				rank(cand[2:0], q.lowest[c]) < rank(top[c][2:0], q.lowest[c]))) begin
				win[c] = cand;
			end
		end
	end

	// ============================================================
	// Next state
	always_comb begin
		logic [2:0] code;
		logic [2:0] lvl;
		logic sel_c;
		logic hit;
		logic [1:0] ack_c;
		next_q = q;
		code = i_io_wdata[CODE_HI:CODE_LO];
		lvl = i_io_wdata[LVL_HI:LVL_LO];
		sel_c = (i_io_addr == PORT_SLAVE_BASE);
		hit = (i_io_addr == PORT_MASTER_BASE) || sel_c;
		ack_c = '0;
		next_q.rvalid = 1'b0;
		next_q.ack_valid = 1'b0;

		// Three stages; a change counts once the last two agree.
		next_q.sync[0] = i_irq;
		for (int s = 1; s < SYNC_STAGES; s++) begin
			next_q.sync[s] = q.sync[s-1];
		end
		for (int b = 0; b < 16; b++) begin
			if (q.sync[1][b] == q.sync[2][b]) begin
				next_q.irq_stable[b] = q.sync[2][b];
			end
		end

		// Reads: a pending poll turns the read into an acknowledge.
		if (i_io_rd) begin
			next_q.rvalid = 1'b1;
			next_q.rdata = 8'h00;
			if (hit) begin
				if (q.poll[sel_c]) begin
					next_q.rdata = {win[sel_c][3], 4'h0, win[sel_c][2:0]};
					next_q.poll[sel_c] = 1'b0;
					ack_c[sel_c] = win[sel_c][3];
				end else if (q.read_isr[sel_c]) begin
					next_q.rdata = q.in_service_register[sel_c];
				end else begin
					next_q.rdata = q.irq_stable[8*sel_c +: 8];
				end
			end
		end

		// Processor acknowledge follows the cascade into the slave.
		if (i_int_ack && win[0][3]) begin
			ack_c[0] = 1'b1;
			ack_c[1] = (win[0][2:0] == 3'(CASCADE_LEVEL)) && win[1][3];
			next_q.ack_valid = 1'b1;
			next_q.ack_level = ack_c[1] ? {1'b1, win[1][2:0]} : {1'b0, win[0][2:0]};
		end
		for (int c = 0; c < 2; c++) begin
			if (ack_c[c] && i_auto_eoi[c] && q.rot_auto[c]) begin
				next_q.lowest[c] = win[c][2:0];
			end
		end

		// Command word writes.
		if (i_io_wr && hit) begin
			if (i_io_wdata[SEL_HI:SEL_LO] == SEL_EOI_ROTATE) begin
				next_q.cmd[sel_c] = code;
				case (code)
					CMD_EOI_NONSPEC: begin
						if (top[sel_c][3]) begin
							next_q.in_service_register[sel_c][top[sel_c][2:0]] = 1'b0;
						end
					end
					CMD_EOI_SPEC: begin
						next_q.in_service_register[sel_c][lvl] = 1'b0;
					end
					CMD_ROT_AUTO_SET: begin
						next_q.rot_auto[sel_c] = 1'b1;
					end
					CMD_ROT_AUTO_CLR: begin
						next_q.rot_auto[sel_c] = 1'b0;
					end
					CMD_ROT_NONSPEC: begin
						if (top[sel_c][3]) begin
							next_q.in_service_register[sel_c][top[sel_c][2:0]] = 1'b0;
							next_q.lowest[sel_c] = top[sel_c][2:0];
						end
					end
					CMD_SET_PRIO: begin
						next_q.lowest[sel_c] = lvl;
					end
					CMD_ROT_SPEC: begin
						next_q.in_service_register[sel_c][lvl] = 1'b0;
						next_q.lowest[sel_c] = lvl;
					end
					default: begin
						next_q.cmd[sel_c] = code;
					end
				endcase
			end else if (i_io_wdata[SEL_HI:SEL_LO] == SEL_MASK_POLL) begin
				if (i_io_wdata[BIT_SPECIAL_ENABLE]) begin
					next_q.special_mask[sel_c] = i_io_wdata[BIT_SPECIAL_MASK];
				end
				next_q.poll[sel_c] = i_io_wdata[BIT_POLL];
				if (i_io_wdata[BIT_READ_ACT]) begin
					next_q.read_isr[sel_c] = i_io_wdata[BIT_READ_ISR];
				end
			end
		end

		// An acknowledge marks its level after any end-of-service write in
		// the same cycle, so a fresh service bit is never lost to a clear.
		for (int c = 0; c < 2; c++) begin
			if (ack_c[c] && !i_auto_eoi[c]) begin
				next_q.in_service_register[c][win[c][2:0]] = 1'b1;
			end
		end

		// Completing the initialization words restores command defaults.
		for (int c = 0; c < 2; c++) begin
			if (i_init_done[c]) begin
				next_q.in_service_register[c] = 8'h00;
				next_q.lowest[c] = RST_LOWEST;
				next_q.rot_auto[c] = 1'b0;
				next_q.cmd[c] = RST_CMD;
				next_q.special_mask[c] = RST_SPECIAL_MASK;
				next_q.read_isr[c] = RST_READ_ISR;
				next_q.poll[c] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			q <= '0;
			q.lowest <= {2{RST_LOWEST}};
			q.cmd <= {2{RST_CMD}};
			q.special_mask <= {2{RST_SPECIAL_MASK}};
			q.read_isr <= {2{RST_READ_ISR}};
		end else begin
			q <= next_q;
		end
	end

	assign o_io_rdata = q.rdata;
	assign o_io_rdata_valid = q.rvalid;
	assign o_intr = win[0][3];
	assign o_ack_level = q.ack_level;
	assign o_ack_valid = q.ack_valid;

	// ============================================================
	// Checks
	logic m_free;
	logic m_wr2;
	logic m_wr3;
	logic [2:0] m_code;
	// The command field is a net so that properties see its sampled value.
	assign m_code = i_io_wdata[CODE_HI:CODE_LO];
	assign m_free = !i_int_ack && !i_io_rd && !i_init_done[0];
	assign m_wr2 = i_io_wr && m_free && i_io_addr == PORT_MASTER_BASE &&
		i_io_wdata[SEL_HI:SEL_LO] == SEL_EOI_ROTATE;
	assign m_wr3 = i_io_wr && m_free && i_io_addr == PORT_MASTER_BASE &&
		i_io_wdata[SEL_HI:SEL_LO] == SEL_MASK_POLL;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	a_reset_defaults: assert property ($rose(i_rst_b) |-> q.cmd[0] == RST_CMD &&
		q.lowest[0] == RST_LOWEST && !q.special_mask[0] && !q.read_isr[0])
		else $error("command defaults wrong after reset");
	a_nonspec_eoi: assert property (m_wr2 && m_code == CMD_EOI_NONSPEC
		&& top[0][3] |=> $countones(q.in_service_register[0]) + 1 ==
		$countones($past(q.in_service_register[0])))
		else $error("non-specific EOI did not clear one bit");
	a_spec_eoi: assert property (m_wr2 && m_code == CMD_EOI_SPEC |=>
		!q.in_service_register[0][$past(i_io_wdata[2:0])] && $stable(q.lowest[0]))
		else $error("specific EOI wrong");
	a_rot_auto: assert property (m_wr2 && m_code == CMD_ROT_AUTO_SET
		|=> q.rot_auto[0]) else $error("auto rotation not set");
	a_set_prio: assert property (m_wr2 && m_code == CMD_SET_PRIO |=>
		q.lowest[0] == $past(i_io_wdata[2:0]) && $stable(q.in_service_register[0]))
		else $error("set priority wrong");
	a_rot_spec: assert property (m_wr2 && m_code == CMD_ROT_SPEC |=>
		q.lowest[0] == $past(i_io_wdata[2:0]) &&
		!q.in_service_register[0][$past(i_io_wdata[2:0])])
		else $error("rotate specific wrong");
	a_smm_hold: assert property (m_wr3 && !i_io_wdata[BIT_SPECIAL_ENABLE]
		|=> $stable(q.special_mask[0])) else $error("special mask changed");
	a_read_select: assert property (q.read_isr[0] && !q.poll[0] &&
		i_io_rd && i_io_addr == PORT_MASTER_BASE
		|=> o_io_rdata == $past(q.in_service_register[0])) else $error("IN_SERVICE_REGISTER read wrong");
	a_read_latch: assert property (m_wr3 && i_io_wdata[BIT_READ_ACT]
		|=> q.read_isr[0] == $past(i_io_wdata[BIT_READ_ISR]))
		else $error("read selection not taken");
	a_read_keep: assert property (m_wr3 && !i_io_wdata[BIT_READ_ACT]
		|=> $stable(q.read_isr[0])) else $error("read selection changed");
	a_poll_read: assert property (q.poll[0] && i_io_rd &&
		i_io_addr == PORT_MASTER_BASE |=> o_io_rdata_valid &&
		o_io_rdata[POLL_VALID_BIT] == $past(win[0][3]))
		else $error("poll byte wrong");
	a_cascade_mask: assert property (i_chan_mask[CASCADE_LEVEL] &&
		i_int_ack |=> !(o_ack_valid && o_ack_level[3]))
		else $error("slave acknowledged through masked cascade");
	a_nested_block: assert property (!q.special_mask[0] &&
		q.lowest[0] == RST_LOWEST && q.in_service_register[0][0] |-> !win[0][3])
		else $error("level blocked by level 0 won");

	c_rot_nonspec: cover property (m_wr2 && m_code == CMD_ROT_NONSPEC);
	c_poll: cover property (q.poll[0] && i_io_rd ##1 o_io_rdata[POLL_VALID_BIT]);
	c_smm: cover property (q.special_mask[0] && o_intr);
	c_slave_ack: cover property (o_ack_valid && o_ack_level[3]);

endmodule

// ==== hw/poc_pkg.sv ====
package poc_pkg;

	// ============================================================
	// Port map and command word layout
	localparam logic [15:0] PORT_MASTER_BASE = 16'h0020;
	localparam logic [15:0] PORT_SLAVE_BASE = 16'h00A0;
	localparam int SEL_HI = 4;
	localparam int SEL_LO = 3;
	localparam logic [1:0] SEL_EOI_ROTATE = 2'h0;
	localparam logic [1:0] SEL_MASK_POLL = 2'h1;
	localparam int CODE_HI = 7;
	localparam int CODE_LO = 5;
	localparam int LVL_HI = 2;
	localparam int LVL_LO = 0;
	localparam int BIT_SPECIAL_MASK = 6;
	localparam int BIT_SPECIAL_ENABLE = 5;
	localparam int BIT_POLL = 2;
	localparam int BIT_READ_ACT = 1;
	localparam int BIT_READ_ISR = 0;
	localparam int CASCADE_LEVEL = 2;
	localparam int POLL_VALID_BIT = 7;

	// ============================================================
	// End-of-service and rotation command codes
	localparam logic [2:0] CMD_ROT_AUTO_CLR = 3'h0;
	localparam logic [2:0] CMD_EOI_NONSPEC = 3'h1;
	localparam logic [2:0] CMD_NOP = 3'h2;
	localparam logic [2:0] CMD_EOI_SPEC = 3'h3;
	localparam logic [2:0] CMD_ROT_AUTO_SET = 3'h4;
	localparam logic [2:0] CMD_ROT_NONSPEC = 3'h5;
	localparam logic [2:0] CMD_SET_PRIO = 3'h6;
	localparam logic [2:0] CMD_ROT_SPEC = 3'h7;

	// ============================================================
	// Values after reset or initialization
	localparam logic [2:0] RST_CMD = CMD_EOI_NONSPEC;
	localparam logic [2:0] RST_LOWEST = 3'h7;
	localparam logic RST_SPECIAL_MASK = 1'b0;
	localparam logic RST_READ_ISR = 1'b0;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic [1:0][7:0] in_service_register;
		logic [1:0][2:0] lowest;
		logic [1:0] rot_auto;
		logic [1:0] special_mask;
		logic [1:0] read_isr;
		logic [1:0] poll;
		logic [1:0][2:0] cmd;
		logic [SYNC_STAGES-1:0][15:0] sync;
		logic [15:0] irq_stable;
		logic [7:0] rdata;
		logic rvalid;
		logic [3:0] ack_level;
		logic ack_valid;
	} poc_state_t;

endpackage
